// [hot_swap_connection_control.sv]
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "hot_swap_regs.svh"

module hot_swap_connection_control (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power and reset inputs.
  input wire logic backend_power_good_n,
  input wire logic power_on_reset_n,
  input wire hot_swap_pkg::pwrup_opt_s pwrup_strap,
  // PLL control.
  output logic pll_reset,
  input wire logic pll_locked,
  // Pad control and reset outputs.
  output hot_swap_pkg::pad_ctrl_s pad_ctrl,
  output logic cpu_bus_reset_out_n,
  output logic second_pci_reset_out_n,
  // Ejector and open-drain pins.
  input wire logic ejector_switch_in,
  output logic indicator_lamp_n_o,
  output logic indicator_lamp_n_oe_n,
  output logic attention_n_o,
  output logic attention_n_oe_n,
  // EEPROM loader handshake.
  output logic eeprom_load_start,
  input wire logic eeprom_load_done,
  // Host configuration access.
  input wire logic cfg_access_req,
  output logic cfg_retry,
  // Interrupt.
  output logic irq
);

  // -----------------------------------------------------------
  // Declarations.
  // -----------------------------------------------------------
  hot_swap_pkg::seq_state_e state_q; // Sequencer state.
  hot_swap_pkg::seq_state_e state_d; // Next sequencer state.
  hot_swap_pkg::pwrup_opt_s opt_q; // Latched options.
  logic por_n_q; // Previous power-on reset level.
  logic ej_meta_q; // Ejector first sync stage.
  logic ej_sync_q; // Ejector second sync stage.
  logic ej_prev_q; // Ejector delayed for edges.
  logic lamp_on_bit_q; // Software lamp request.
  logic board_added_flag_q; // Insertion event flag.
  logic removal_request_flag_q; // Removal event flag.
  logic armed_q; // Board-added may fire.
  logic config_retry_hold_q; // Retry all config cycles.
  logic [2:0] istat_q; // Sticky interrupt status.
  logic [2:0] imask_q; // Interrupt mask.
  logic load_q; // EEPROM load start pulse.
  logic lamp_oe_n_q; // Lamp drive enable, low drives.
  logic [31:0] rdata_q; // Read data register.
  logic held; // Internal resources in reset.
  logic wr_acc; // Write access phase.
  logic rd_acc; // Read access phase.
  logic mapped; // Address hits a register.
  logic set_added; // Ejector closure event.
  logic set_removal; // Ejector opening event.
  logic clr_added; // Host clears board-added.
  logic clr_removal; // Host clears removal flag.
  logic run_entry; // Sequencer enters run.

  // -----------------------------------------------------------
  // Bus decode.
  // -----------------------------------------------------------

  // Zero wait state slave; unmapped offsets answer with error.
  assign mapped = (paddr == `SWAP_CSR_OFF) ||
                  (paddr == `HOLD_CTRL_OFF) ||
                  (paddr == `IRQ_STAT_OFF) ||
                  (paddr == `IRQ_MASK_OFF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite && mapped;
  assign prdata = rdata_q;

  // Internal resources stay reset until the run state.
  assign held = (state_q != hot_swap_pkg::ST_RUN);
  assign run_entry = (state_q == hot_swap_pkg::ST_LOCK) && pll_locked;

  // -----------------------------------------------------------
  // Power sequencer.
  // -----------------------------------------------------------

  // Next state from power-good, power-on reset and PLL lock.
  always_comb begin
    state_d = state_q;
    case (state_q)
      hot_swap_pkg::ST_DARK: begin
        if (!backend_power_good_n) begin
          state_d = hot_swap_pkg::ST_PORST;
        end
      end
      hot_swap_pkg::ST_PORST: begin
        if (power_on_reset_n) begin
          state_d = hot_swap_pkg::ST_LOCK;
        end
      end
      hot_swap_pkg::ST_LOCK: begin
        if (pll_locked) begin
          state_d = hot_swap_pkg::ST_RUN;
        end
      end
      hot_swap_pkg::ST_RUN: begin
        state_d = hot_swap_pkg::ST_RUN;
      end
      default: begin
        state_d = hot_swap_pkg::ST_DARK;
      end
    endcase
    // Loss of power-good or a new power-on reset wins.
    if (backend_power_good_n) begin
      state_d = hot_swap_pkg::ST_DARK;
    end else if (!power_on_reset_n &&
                 state_q != hot_swap_pkg::ST_DARK) begin
      state_d = hot_swap_pkg::ST_PORST;
    end
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= hot_swap_pkg::ST_DARK;
    end else begin
      state_q <= state_d;
    end
  end

  // Pads disabled and receivers inhibited while dark.
  assign pad_ctrl.out_enable = (state_q != hot_swap_pkg::ST_DARK);
  assign pad_ctrl.rx_inhibit = (state_q == hot_swap_pkg::ST_DARK);
  // PLLs are held until power-on reset has ended.
  assign pll_reset = (state_q == hot_swap_pkg::ST_DARK) ||
                     (state_q == hot_swap_pkg::ST_PORST);
  // Both reset outputs low until PLL lock completes.
  assign cpu_bus_reset_out_n = !held;
  assign second_pci_reset_out_n = !held;

  // Latch the option straps as power-on reset is released.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      por_n_q <= 1'b0;
      opt_q <= '0;
    end else begin
      por_n_q <= power_on_reset_n;
      if (power_on_reset_n && !por_n_q) begin
        opt_q <= pwrup_strap;
      end
    end
  end

  // One load pulse only as the sequence enters run.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      load_q <= 1'b0;
    end else begin
      load_q <= run_entry && opt_q.eeprom_load;
    end
  end
  assign eeprom_load_start = load_q;

  // -----------------------------------------------------------
  // Ejector synchroniser.
  // -----------------------------------------------------------

  // Two stages, then a delayed copy for edge detection.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ej_meta_q <= 1'b0;
      ej_sync_q <= 1'b0;
      ej_prev_q <= 1'b0;
    end else begin
      ej_meta_q <= ejector_switch_in;
      ej_sync_q <= ej_meta_q;
      ej_prev_q <= ej_sync_q;
    end
  end

  // High means latch closed, low means open.
  assign set_added = !held && armed_q && ej_sync_q;
  assign set_removal = !held && ej_prev_q && !ej_sync_q;

  // -----------------------------------------------------------
  // Hot swap control and status register.
  // -----------------------------------------------------------

  // Write one to clear either event flag.
  assign clr_added = wr_acc && (paddr == `SWAP_CSR_OFF) &&
                     pwdata[`SWAP_ADDED_BIT];
  assign clr_removal = wr_acc && (paddr == `SWAP_CSR_OFF) &&
                       pwdata[`SWAP_REMOVAL_BIT];

  // Flags reset while held; a set beats a same-cycle clear.
  always_ff @(posedge mclk) begin
    if (sys_rst || held) begin
      board_added_flag_q <= 1'b0;
      removal_request_flag_q <= 1'b0;
      armed_q <= 1'b1;
    end else begin
      if (set_added) begin
        board_added_flag_q <= 1'b1;
      end else if (clr_added) begin
        board_added_flag_q <= 1'b0;
      end
      if (set_removal) begin
        removal_request_flag_q <= 1'b1;
      end else if (clr_removal) begin
        removal_request_flag_q <= 1'b0;
      end
      // Firing disarms; clearing the removal flag re-arms.
      if (set_added) begin
        armed_q <= 1'b0;
      end else if (clr_removal && removal_request_flag_q) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Software lamp request, cleared with internal reset.
  always_ff @(posedge mclk) begin
    if (sys_rst || held) begin
      lamp_on_bit_q <= 1'b0;
    end else if (wr_acc && paddr == `SWAP_CSR_OFF) begin
      lamp_on_bit_q <= pwdata[`SWAP_LAMP_BIT];
    end
  end

  // Lamp driven low when dark or when software asks.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lamp_oe_n_q <= 1'b0;
    end else begin
      lamp_oe_n_q <= !((state_d == hot_swap_pkg::ST_DARK) ||
                       (lamp_on_bit_q && !held));
    end
  end
  assign indicator_lamp_n_o = 1'b0;
  assign indicator_lamp_n_oe_n = lamp_oe_n_q;

  // Open-drain attention line pulled low while a flag is set.
  assign attention_n_o = 1'b0;
  assign attention_n_oe_n = !(board_added_flag_q ||
                              removal_request_flag_q);

  // -----------------------------------------------------------
  // Configuration retry hold.
  // -----------------------------------------------------------

  // Set in reset; cleared by load, processor write or boot option.
  always_ff @(posedge mclk) begin
    if (sys_rst || held && !run_entry) begin
      config_retry_hold_q <= `RETRY_HOLD_RST;
    end else if (run_entry && opt_q.boot_pci == `BOOT_PCI_CODE) begin
      config_retry_hold_q <= 1'b0;
    end else if (eeprom_load_done) begin
      config_retry_hold_q <= 1'b0;
    end else if (wr_acc && paddr == `HOLD_CTRL_OFF) begin
      config_retry_hold_q <= pwdata[`HOLD_RETRY_BIT];
    end
  end
  assign cfg_retry = cfg_access_req && config_retry_hold_q;

  // -----------------------------------------------------------
  // Interrupts.
  // -----------------------------------------------------------

  // Sticky events; a status read clears, a new event wins.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      istat_q <= '0;
      imask_q <= `IRQ_MASK_RST;
    end else begin
      if (rd_acc && paddr == `IRQ_STAT_OFF) begin
        istat_q <= '0;
      end
      if (set_added) begin
        istat_q[`IRQ_ADDED_BIT] <= 1'b1;
      end
      if (set_removal) begin
        istat_q[`IRQ_REMOVAL_BIT] <= 1'b1;
      end
      if (run_entry) begin
        istat_q[`IRQ_READY_BIT] <= 1'b1;
      end
      if (wr_acc && paddr == `IRQ_MASK_OFF) begin
        imask_q <= pwdata[2:0];
      end
    end
  end
  assign irq = |(istat_q & imask_q);

  // -----------------------------------------------------------
  // Read data.
  // -----------------------------------------------------------

  // Read data captured in the setup phase.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (psel && !penable) begin
      rdata_q <= '0;
      case (paddr)
        `SWAP_CSR_OFF: begin
          rdata_q[`SWAP_LAMP_BIT] <= lamp_on_bit_q;
          rdata_q[`SWAP_REMOVAL_BIT] <= removal_request_flag_q;
          rdata_q[`SWAP_ADDED_BIT] <= board_added_flag_q;
          rdata_q[`SWAP_ARMED_BIT] <= armed_q;
          rdata_q[`SWAP_EJECT_BIT] <= ej_sync_q;
        end
        `HOLD_CTRL_OFF: begin
          rdata_q[`HOLD_RETRY_BIT] <= config_retry_hold_q;
          rdata_q[`HOLD_BOOT_BIT] <= opt_q.boot_pci;
          rdata_q[`HOLD_LOAD_BIT] <= opt_q.eeprom_load;
          rdata_q[`HOLD_STATE_LSB +: 4] <= state_q;
        end
        `IRQ_STAT_OFF: begin
          rdata_q[2:0] <= istat_q;
        end
        `IRQ_MASK_OFF: begin
          rdata_q[2:0] <= imask_q;
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------
  // Assertions.
  // -----------------------------------------------------------

  AST_DARK_ON_LOSS: assert property (@(posedge mclk) disable iff (sys_rst)
    backend_power_good_n |=> !pad_ctrl.out_enable && pad_ctrl.rx_inhibit
    && !cpu_bus_reset_out_n)
    else $error("Pads or resets active without power good.");
  AST_LAMP_DARK: assert property (@(posedge mclk) disable iff (sys_rst)
    backend_power_good_n ##1 backend_power_good_n
    |-> !indicator_lamp_n_oe_n)
    else $error("Lamp not lit while power good negated.");
  AST_PG_RISE: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(backend_power_good_n) && !power_on_reset_n ##1
    !backend_power_good_n |-> pad_ctrl.out_enable && indicator_lamp_n_oe_n
    && !cpu_bus_reset_out_n && !second_pci_reset_out_n)
    else $error("Power good rise sequence wrong.");
  AST_OPT_LATCH: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(power_on_reset_n) |=> opt_q == $past(pwrup_strap))
    else $error("Power-up options not latched.");
  AST_LOCK_RELEASE: assert property (@(posedge mclk) disable iff (sys_rst)
    state_q == hot_swap_pkg::ST_LOCK && !pll_locked
    |-> !pll_reset && !cpu_bus_reset_out_n)
    else $error("Resets released before PLL lock.");
  AST_LOAD_ONCE: assert property (@(posedge mclk) disable iff (sys_rst)
    eeprom_load_start |-> $past(run_entry) && $past(opt_q.eeprom_load))
    else $error("EEPROM load started outside reset exit.");
  AST_ADDED: assert property (@(posedge mclk) disable iff (sys_rst)
    set_added && !backend_power_good_n |=>
    board_added_flag_q && !attention_n_oe_n)
    else $error("Closure did not raise board-added.");
  AST_RETRY: assert property (@(posedge mclk) disable iff (sys_rst)
    held && !run_entry && cfg_access_req |=> config_retry_hold_q)
    else $error("Retry hold not set in reset.");
  AST_REMOVAL: assert property (@(posedge mclk) disable iff (sys_rst)
    set_removal && !backend_power_good_n |=>
    removal_request_flag_q && !attention_n_oe_n)
    else $error("Opening did not raise removal flag.");
  AST_REARM: assert property (@(posedge mclk) disable iff (sys_rst)
    !held && clr_removal && removal_request_flag_q && !set_removal &&
    !backend_power_good_n && power_on_reset_n
    |=> armed_q && !removal_request_flag_q)
    else $error("Removal clear did not re-arm.");

  COV_INSERT: cover property (@(posedge mclk) disable iff (sys_rst)
    run_entry ##[1:50] set_added);
  COV_REMOVE: cover property (@(posedge mclk) disable iff (sys_rst)
    set_removal ##[1:50] clr_removal);
  COV_RETRY: cover property (@(posedge mclk) disable iff (sys_rst)
    cfg_retry);

endmodule // hot_swap_connection_control

// [hot_swap_regs.svh]
`ifndef HOT_SWAP_REGS_SVH
`define HOT_SWAP_REGS_SVH
// Operation
// - Pins disabled while power-good negated, lamp excepted
// - Input receivers inhibited while power-good negated
// - Power-good negated: hold reset, light lamp
// - Power-good asserted: lamp released, outputs on, resets
// - Latch power-up options when power-on reset ends
// - Release PLLs; after lock, release resets
// - Start EEPROM load or idle per option
// - Ejector closed after reset: board-added, attention
// - Retry hold resets set; retries configuration cycles
// - Host clears board-added; attention negates
// - Retry hold cleared by load, processor, boot
// - Ejector opens: removal flag, attention asserted
// - Host clears removal; attention off, re-arm
// - Host lamp-on bit lights the lamp
// - No EEPROM reload on re-closure or extraction
// - Ejector low means open, high means closed
// - Lamp lit by driving open-drain output low

// -----------------------------------------------------------
// Register offsets (byte addresses).
// -----------------------------------------------------------
`define SWAP_CSR_OFF 12'h000
`define HOLD_CTRL_OFF 12'h004
`define IRQ_STAT_OFF 12'h008
`define IRQ_MASK_OFF 12'h00C

// -----------------------------------------------------------
// Field positions.
// -----------------------------------------------------------
`define SWAP_LAMP_BIT 0
`define SWAP_REMOVAL_BIT 1
`define SWAP_ADDED_BIT 2
`define SWAP_ARMED_BIT 3
`define SWAP_EJECT_BIT 4
`define HOLD_RETRY_BIT 0
`define HOLD_BOOT_BIT 1
`define HOLD_LOAD_BIT 2
`define HOLD_STATE_LSB 4
`define IRQ_ADDED_BIT 0
`define IRQ_REMOVAL_BIT 1
`define IRQ_READY_BIT 2

// -----------------------------------------------------------
// Reset values and the PCI boot code.
// -----------------------------------------------------------
`define RETRY_HOLD_RST 1'b1
`define IRQ_MASK_RST 3'h0
`define BOOT_PCI_CODE 1'b1

`endif

// [hot_swap_pkg.sv]
package hot_swap_pkg;

  // -----------------------------------------------------------
  // Sequencer states, one-hot.
  // -----------------------------------------------------------
  typedef enum logic [3:0] {
    ST_DARK = 4'b0001,
    ST_PORST = 4'b0010,
    ST_LOCK = 4'b0100,
    ST_RUN = 4'b1000
  } seq_state_e;

  // Pad control bundle for the device's I/O ring.
  typedef struct packed {
    logic out_enable;
    logic rx_inhibit;
  } pad_ctrl_s;

  // Latched power-up options.
  typedef struct packed {
    logic boot_pci;
    logic eeprom_load;
  } pwrup_opt_s;

endpackage

// [card_power_model.sv]
`timescale 1ns/1ps

// Stands in for the on-card power sequencer, the PLLs and the EEPROM loader.
module card_power_model (
  // Clock.
  input wire logic mclk,
  // Back-end power request from the bench.
  input wire logic power_on,
  // Power and PLL lines into the block.
  output logic backend_power_good_n,
  output logic power_on_reset_n,
  input wire logic pll_reset,
  output logic pll_locked,
  // Loader handshake and a count of loads started.
  input wire logic eeprom_load_start,
  output logic eeprom_load_done,
  output logic [7:0] load_count
);
  logic [4:0] step_q; // Cycles since power was requested.
  logic [2:0] busy_q; // Loader countdown.

  // Power ramps: good first, then power-up reset ends, then PLL lock.
  always @(posedge mclk) begin
    if (!power_on) begin
      step_q <= 5'h00;
    end else if (step_q != 5'h1F) begin
      step_q <= step_q + 5'h01;
    end
    backend_power_good_n <= !(power_on && step_q >= 5'h02);
    power_on_reset_n <= power_on && step_q >= 5'h06;
    // Lock only once the PLLs are out of reset, never before.
    pll_locked <= power_on && step_q >= 5'h0A && !pll_reset;
  end

  // Loader answers a start pulse three cycles later with a done pulse.
  always @(posedge mclk) begin
    eeprom_load_done <= (busy_q == 3'h1);
    if (eeprom_load_start) begin
      busy_q <= 3'h3;
      load_count <= load_count + 8'h01;
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
    end
  end

  initial begin
    step_q = 5'h00;
    busy_q = 3'h0;
    load_count = 8'h00;
    eeprom_load_done = 1'b0;
    backend_power_good_n = 1'b1;
    power_on_reset_n = 1'b0;
    pll_locked = 1'b0;
  end
endmodule // card_power_model

// [test_hot_swap_connection_control.sv]
`timescale 1ns/1ps
`include "hot_swap_regs.svh"

module test_hot_swap_connection_control;
  // -----------------------------------------------------------
  // Signals.
  // -----------------------------------------------------------
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, backend_power_good_n, power_on_reset_n, pll_reset, pll_locked;
  logic cpu_bus_reset_out_n, second_pci_reset_out_n, ejector_switch_in;
  logic indicator_lamp_n_o, indicator_lamp_n_oe_n, attention_n_o;
  logic attention_n_oe_n, eeprom_load_start, eeprom_load_done;
  logic cfg_access_req, cfg_retry, irq, power_on;
  logic [7:0] load_count;
  hot_swap_pkg::pwrup_opt_s pwrup_strap;
  hot_swap_pkg::pad_ctrl_s pad_ctrl;
  int errors, samples_checked, n;

  hot_swap_connection_control hot_swap_connection_control_inst (.*);
  card_power_model card_power_model_inst (.*);

  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  // -----------------------------------------------------------
  // Tasks.
  // -----------------------------------------------------------
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer: setup, then access until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits, within a bound, for the back-end reset outputs to change.
  task automatic wait_run(input logic lvl);
    for (n = 0; n < 100 && cpu_bus_reset_out_n !== lvl; n++) begin
      @(posedge mclk);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #300000;
    errors++;
    finish_test();
  end

  // -----------------------------------------------------------
  // Test sequence.
  // -----------------------------------------------------------
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {errors, samples_checked} = '0;
    power_on = 1'b0;
    ejector_switch_in = 1'b0;
    cfg_access_req = 1'b1;
    pwrup_strap = 2'b01;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk(pad_ctrl, 2'b01);
    chk({indicator_lamp_n_oe_n, indicator_lamp_n_o}, 2'b00);
    chk({cpu_bus_reset_out_n, second_pci_reset_out_n}, 2'b00);
    $display("test dark done");
    // Power up with an EEPROM load and local boot.
    power_on <= 1'b1;
    for (n = 0; n < 100 && pad_ctrl.out_enable !== 1'b1; n++) begin
      @(posedge mclk);
    end
    chk({pad_ctrl, indicator_lamp_n_oe_n}, 3'b101);
    chk({cpu_bus_reset_out_n, second_pci_reset_out_n, pll_reset}, 3'b001);
    wait_run(1'b1);
    chk({second_pci_reset_out_n, pll_reset, cfg_retry}, 3'b101);
    repeat (6) @(posedge mclk);
    chk({load_count, cfg_retry}, 9'h002);
    apb(1'b0, `HOLD_CTRL_OFF, 32'h0000_0000);
    chk(rd & 32'h0000_00F7, 32'h0000_0084);
    $display("test power up done");
    // Ejector closure raises board added; host clears it.
    ejector_switch_in <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(attention_n_oe_n, 1'b0);
    apb(1'b0, `SWAP_CSR_OFF, 32'h0000_0000);
    chk(rd & 32'h0000_0017, 32'h0000_0014);
    apb(1'b1, `SWAP_CSR_OFF, 32'h0000_0004);
    @(posedge mclk);
    chk(attention_n_oe_n, 1'b1);
    apb(1'b0, `IRQ_STAT_OFF, 32'h0000_0000);
    apb(1'b1, `IRQ_MASK_OFF, 32'h0000_0001);
    $display("test insertion done");
    // Ejector opens: removal flag, masked interrupt stays low.
    ejector_switch_in <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({attention_n_oe_n, irq}, 2'b00);
    apb(1'b0, `SWAP_CSR_OFF, 32'h0000_0000);
    chk(rd & 32'h0000_0007, 32'h0000_0002);
    apb(1'b1, `SWAP_CSR_OFF, 32'h0000_0002);
    apb(1'b0, `SWAP_CSR_OFF, 32'h0000_0000);
    chk({rd & 32'h0000_000E, 31'h0, attention_n_oe_n}, 64'h8_0000_0001);
    apb(1'b1, `SWAP_CSR_OFF, 32'h0000_0001);
    // The lamp drive is a register behind the lamp bit: two edges.
    repeat (2) @(posedge mclk);
    chk(indicator_lamp_n_oe_n, 1'b0);
    // Re-closure after the lamp: added again, no reload.
    ejector_switch_in <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({attention_n_oe_n, irq, load_count}, 10'h101);
    apb(1'b0, `IRQ_STAT_OFF, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0001);
    @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000);
    $display("test extraction done");
    // Power lost: everything back in reset, lamp lit.
    power_on <= 1'b0;
    wait_run(1'b0);
    repeat (3) @(posedge mclk);
    chk({pad_ctrl, indicator_lamp_n_oe_n}, 3'b010);
    chk({second_pci_reset_out_n, cfg_retry, attention_n_oe_n}, 3'b011);
    // Boot from PCI without a load clears the retry hold itself.
    pwrup_strap <= 2'b10;
    power_on <= 1'b1;
    wait_run(1'b1);
    repeat (2) @(posedge mclk);
    chk({load_count, cfg_retry}, 9'h002);
    $display("test pci boot done");
    finish_test();
  end
endmodule // test_hot_swap_connection_control
